// File: verilog/lem_pkg.sv
// Shared constants and types of the link event monitor.
package lem_pkg;
   localparam int DATA_W = 32;
   localparam int CTR_W = 48;
   localparam int INC_W = 9;
   localparam int XTRA_W = 26;
   // Event codes.
   localparam logic [7:0] EV_RETRY_SENT = 8'h08;
   localparam logic [7:0] EV_CRC_ERR = 8'h0b;
   localparam logic [7:0] EV_FLIT_CLASS = 8'h03;
   localparam logic [7:0] EV_HDR_MATCH = 8'h05;
   localparam logic [7:0] EV_SHUTDOWN = 8'h21;
   localparam logic [7:0] EV_ACK = 8'h22;
   localparam logic [7:0] EV_NACK = 8'h23;
   localparam logic [7:0] EV_RX_FULL = 8'h24;
   localparam logic [7:0] EV_RX_HALF = 8'h25;
   localparam logic [7:0] EV_ALLOC = 8'h30;
   localparam logic [7:0] EV_SKIP = 8'h31;
   localparam logic [7:0] EV_FILL = 8'h32;
   localparam logic [7:0] EV_CRD_SHARED = 8'h38;
   localparam logic [7:0] EV_CRD_VN0 = 8'h39;
   localparam logic [7:0] EV_CRD_VN1 = 8'h3a;
   // Field positions.
   localparam int CTL_MASK_LSB = 8;
   localparam int CTL_EDGE_BIT = 18;
   localparam int CTL_EN_BIT = 22;
   localparam int MASK_RX = 0;
   localparam int MASK_TX = 1;
   localparam int MASK_DATA = 3;
   localparam int MASK_CRD = 4;
   localparam int MASK_NULL = 5;
   localparam int MASK_CTRL = 6;
   localparam int MASK_HDR = 7;
   localparam int XTRA_OPC_BIT = 0;
   localparam int PWR_ALLOW_BIT = 2;
   localparam int PWR_REQ_BIT = 3;
   // Register offsets; counter n sits at n times the stride.
   localparam logic [3:0] REG_CTL_LO = 4'h0;
   localparam logic [3:0] REG_CTL_HI = 4'h4;
   localparam logic [3:0] REG_CTR_LO = 4'h8;
   localparam logic [3:0] REG_CTR_HI = 4'hc;
   localparam logic [7:0] REG_PWR_CTL = 8'h40;
   localparam logic [7:0] REG_STATUS = 8'h44;
   // Writable bits and reset values.
   localparam logic [31:0] CTL_LO_RW = 32'h0044ffff;
   localparam logic [31:0] CTL_LO_RST = 32'h00000000;
   localparam logic [25:0] CTL_HI_RST = 26'h0000000;
   localparam logic [2:0] PWR_CTL_RST = 3'h4;
   // Slot content codes.
   localparam logic [2:0] SLOT_NULL = 3'h0;
   localparam logic [2:0] SLOT_HDR = 3'h1;
   localparam logic [2:0] SLOT_CRD_FULL = 3'h2;
   localparam logic [2:0] SLOT_CRD_EMPTY = 3'h3;
   localparam logic [2:0] SLOT_CTRL = 3'h4;
   // Link power states, Gray along full, half, shut down.
   typedef enum logic [1:0] {
      LEM_PWR_FULL = 2'b00,
      LEM_PWR_HALF = 2'b01,
      LEM_PWR_SHUT = 2'b11
   } lem_pwr_t;
   typedef enum logic {
      LEM_TX_IDLE = 1'b0,
      LEM_TX_WAIT = 1'b1
   } lem_txreq_t;
endpackage

// File: verilog/lem_event_sel.sv
// Event selection and per-cycle increment for one counter.
`timescale 1ns/1ps
module lem_event_sel (
   // Counter selection.
   input wire logic [7:0] code_in,
   input wire logic [7:0] umask_in,
   input wire logic opc_en_in,
   // Power and handshake state.
   input wire logic [1:0] rx_state_in,
   input wire logic [3:0] hshake_in,
   // Error and retry.
   input wire logic crc_err_in,
   input wire logic retry_sent_in,
   // Credits and queue.
   input wire logic [8:0] credit_in,
   input wire logic [2:0] alloc_in,
   input wire logic [2:0] skip_in,
   input wire logic [14:0] fill_in,
   // Flit content.
   input wire logic flit_valid_in,
   input wire logic data_flit_in,
   input wire logic dual_slot_in,
   input wire logic [8:0] slot_type_in,
   input wire logic [11:0] hdr_class_in,
   input wire logic [11:0] hdr_opc_in,
   // Increment.
   output logic [8:0] inc_out
);
   // Count of set bits, widened to an increment.
   function automatic logic [8:0] pop3(input logic [2:0] v);
      pop3 = {8'h00, v[0]} + {8'h00, v[1]} + {8'h00, v[2]};
   endfunction

   wire [2:0] slot_en = umask_in[2:0];
   wire [2:0] flit_hit;
   wire [2:0] hdr_hit;
   wire [8:0] fill_sum;

   // Per-slot classification; any selected class hits.
   for (genvar s = 0; s < 3; s++) begin : g_slot
      wire [2:0] t = slot_type_in[3*s +: 3];
      wire crd = umask_in[lem_pkg::MASK_CRD] && s == 2
         && t == lem_pkg::SLOT_CRD_FULL;
      wire nul = umask_in[lem_pkg::MASK_NULL]
         && (t == lem_pkg::SLOT_NULL || t == lem_pkg::SLOT_CRD_EMPTY)
         && !(s == 1 && dual_slot_in);
      wire ctl = umask_in[lem_pkg::MASK_CTRL] && s == 0
         && t == lem_pkg::SLOT_CTRL;
      wire hdr = umask_in[lem_pkg::MASK_HDR]
         && t == lem_pkg::SLOT_HDR;
      assign flit_hit[s] = slot_en[s] && flit_valid_in && !data_flit_in
         && (crd || nul || ctl || hdr);
      // Class match, with optional opcode compare.
      assign hdr_hit[s] = flit_valid_in && !data_flit_in
         && t == lem_pkg::SLOT_HDR
         && hdr_class_in[4*s +: 4] == umask_in[3:0]
         && (!opc_en_in || hdr_opc_in[4*s +: 4] == umask_in[7:4]);
   end

   // Queue fill, summed over enabled slots.
   assign fill_sum = {4'h0, fill_in[4:0] & {5{slot_en[0]}}}
      + {4'h0, fill_in[9:5] & {5{slot_en[1]}}}
      + {4'h0, fill_in[14:10] & {5{slot_en[2]}}};

   // A data flit counts once per enabled slot.
   wire [8:0] data_cnt = (flit_valid_in && data_flit_in
      && umask_in[lem_pkg::MASK_DATA]) ? pop3(slot_en) : 9'h000;
   wire [8:0] flit_cnt = pop3(flit_hit) + data_cnt;
   wire ack_hit = (umask_in[lem_pkg::MASK_RX] && hshake_in[0])
      || (umask_in[lem_pkg::MASK_TX] && hshake_in[1]);
   wire nack_hit = (umask_in[lem_pkg::MASK_RX] && hshake_in[2])
      || (umask_in[lem_pkg::MASK_TX] && hshake_in[3]);

   // Event code selects the increment.
   assign inc_out =
      (code_in == lem_pkg::EV_SHUTDOWN) ?
         {8'h00, rx_state_in == lem_pkg::LEM_PWR_SHUT} :
      (code_in == lem_pkg::EV_RX_FULL) ?
         {8'h00, rx_state_in == lem_pkg::LEM_PWR_FULL} :
      (code_in == lem_pkg::EV_RX_HALF) ?
         {8'h00, rx_state_in == lem_pkg::LEM_PWR_HALF} :
      (code_in == lem_pkg::EV_ACK) ? {8'h00, ack_hit} :
      (code_in == lem_pkg::EV_NACK) ? {8'h00, nack_hit} :
      (code_in == lem_pkg::EV_CRC_ERR) ? {8'h00, crc_err_in} :
      (code_in == lem_pkg::EV_RETRY_SENT) ?
         {8'h00, retry_sent_in} :
      (code_in == lem_pkg::EV_CRD_SHARED) ? pop3(credit_in[2:0]) :
      (code_in == lem_pkg::EV_CRD_VN0) ? pop3(credit_in[5:3]) :
      (code_in == lem_pkg::EV_CRD_VN1) ? pop3(credit_in[8:6]) :
      (code_in == lem_pkg::EV_ALLOC) ? pop3(alloc_in & slot_en) :
      (code_in == lem_pkg::EV_SKIP) ? pop3(skip_in & slot_en) :
      (code_in == lem_pkg::EV_FILL) ? fill_sum :
      (code_in == lem_pkg::EV_FLIT_CLASS) ? flit_cnt :
      (code_in == lem_pkg::EV_HDR_MATCH) ? pop3(hdr_hit) :
      9'h000;
endmodule

// File: verilog/lem_counter.sv
// One general event counter with load and edge detection.
`timescale 1ns/1ps
module lem_counter (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Control.
   input wire logic enable_in,
   input wire logic edge_in,
   input wire logic [8:0] inc_in,
   // Software load.
   input wire logic load_lo_in,
   input wire logic load_hi_in,
   input wire logic [31:0] wdata_in,
   // Count.
   output logic [47:0] count_out
);
   logic [47:0] count_q;
   logic active_q;
   wire event_now = inc_in != 9'h000;
   // Edge mode counts only the first cycle of a run.
   wire [8:0] step = edge_in ? {8'h00, event_now && !active_q} : inc_in;
   wire [47:0] count_d = count_q + {39'h0, step};

   // Software load takes precedence over counting.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_q <= 48'h0;
         active_q <= 1'b0;
      end else begin
         active_q <= event_now;
         if (load_lo_in) begin
            count_q <= {count_q[47:32], wdata_in};
         end else if (load_hi_in) begin
            count_q <= {wdata_in[15:0], count_q[31:0]};
         end else if (enable_in) begin
            count_q <= count_d;
         end
      end
   end

   assign count_out = count_q;
endmodule

// File: verilog/lem_link_monitor.sv
// Receive-side and power event monitor of a coherent link agent.
`timescale 1ns/1ps
module lem_link_monitor (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Register port.
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Power change, peer requests and our answers.
   input wire logic peer_pwr_req_in,
   input wire logic [1:0] peer_pwr_target_in,
   output logic power_change_accept_out,
   output logic power_change_refuse_out,
   // Power change, our requests and peer answers.
   output logic pwr_req_out,
   output logic [1:0] pwr_target_out,
   input wire logic power_change_accept_in,
   input wire logic power_change_refuse_in,
   // Power state view.
   output logic [1:0] rx_state_out,
   output logic [1:0] tx_state_out,
   // Received flits.
   input wire logic rx_flit_valid_in,
   input wire logic rx_checksum_bad_in,
   input wire logic rx_data_flit_in,
   input wire logic rx_dual_slot_in,
   input wire logic [8:0] rx_slot_type_in,
   input wire logic [11:0] rx_hdr_class_in,
   input wire logic [11:0] rx_hdr_opc_in,
   // Link level retry.
   output logic retry_req_out,
   input wire logic retry_ack_in,
   // Credits and receive flit queue.
   input wire logic [8:0] rx_credit_in,
   input wire logic [2:0] rxq_alloc_in,
   input wire logic [2:0] rxq_skip_in,
   input wire logic [14:0] rxq_fill_in
);
   // Event stage: every link input is registered once.
   logic ev_valid_q;
   logic ev_bad_q;
   logic ev_data_q;
   logic ev_dual_q;
   logic [8:0] ev_type_q;
   logic [11:0] ev_class_q;
   logic [11:0] ev_opc_q;
   logic [8:0] ev_credit_q;
   logic [2:0] ev_alloc_q;
   logic [2:0] ev_skip_q;
   logic [14:0] ev_fill_q;
   logic ev_acc_in_q;
   logic ev_ref_in_q;
   logic ev_peer_req_q;
   logic [1:0] ev_peer_tgt_q;
   logic ev_retry_ack_q;

   // Register state.
   logic [31:0] ctl_lo_q [4];
   logic [25:0] ctl_hi_q [4];
   logic [2:0] pwr_ctl_q;
   logic [31:0] rdata_q;

   // Power handshake and retry state.
   lem_pkg::lem_pwr_t rx_state_q;
   lem_pkg::lem_pwr_t tx_state_q;
   lem_pkg::lem_txreq_t txreq_q;
   logic [1:0] tx_target_q;
   logic pwr_req_q;
   logic accept_q;
   logic refuse_q;
   logic retry_req_q;
   logic retry_pend_q;

   // Counter values.
   logic [47:0] count_w [4];

   // Event inputs come from same-clock logic; one stage eases timing.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ev_valid_q <= 1'b0;
         ev_bad_q <= 1'b0;
         ev_data_q <= 1'b0;
         ev_dual_q <= 1'b0;
         ev_type_q <= 9'h000;
         ev_class_q <= 12'h000;
         ev_opc_q <= 12'h000;
         ev_credit_q <= 9'h000;
         ev_alloc_q <= 3'h0;
         ev_skip_q <= 3'h0;
         ev_fill_q <= 15'h0000;
      end else begin
         ev_valid_q <= rx_flit_valid_in;
         ev_bad_q <= rx_flit_valid_in && rx_checksum_bad_in;
         ev_data_q <= rx_data_flit_in;
         ev_dual_q <= rx_dual_slot_in;
         ev_type_q <= rx_slot_type_in;
         ev_class_q <= rx_hdr_class_in;
         ev_opc_q <= rx_hdr_opc_in;
         ev_credit_q <= rx_credit_in;
         ev_alloc_q <= rxq_alloc_in;
         ev_skip_q <= rxq_skip_in;
         ev_fill_q <= rxq_fill_in;
      end
   end

   // Handshake inputs pass the same stage.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ev_acc_in_q <= 1'b0;
         ev_ref_in_q <= 1'b0;
         ev_peer_req_q <= 1'b0;
         ev_peer_tgt_q <= 2'b00;
         ev_retry_ack_q <= 1'b0;
      end else begin
         ev_acc_in_q <= power_change_accept_in;
         ev_ref_in_q <= power_change_refuse_in;
         ev_peer_req_q <= peer_pwr_req_in;
         ev_peer_tgt_q <= peer_pwr_target_in;
         ev_retry_ack_q <= retry_ack_in;
      end
   end

   // Address decode.
   wire ctr_area = reg_addr_in[7:6] == 2'b00;
   wire [1:0] idx = reg_addr_in[5:4];
   wire [3:0] sub = reg_addr_in[3:0];
   wire wr_ctl_lo = reg_wr_in && ctr_area && sub == lem_pkg::REG_CTL_LO;
   wire wr_ctl_hi = reg_wr_in && ctr_area && sub == lem_pkg::REG_CTL_HI;
   wire wr_ctr_lo = reg_wr_in && ctr_area && sub == lem_pkg::REG_CTR_LO;
   wire wr_ctr_hi = reg_wr_in && ctr_area && sub == lem_pkg::REG_CTR_HI;
   wire wr_pwr = reg_wr_in && reg_addr_in == lem_pkg::REG_PWR_CTL;
   wire tx_start = wr_pwr && reg_wdata_in[lem_pkg::PWR_REQ_BIT]
      && txreq_q == lem_pkg::LEM_TX_IDLE;

   // Read data for the counter area and the loose registers.
   wire [31:0] ctr_rd =
      (sub == lem_pkg::REG_CTL_LO) ? ctl_lo_q[idx] :
      (sub == lem_pkg::REG_CTL_HI) ? {6'h00, ctl_hi_q[idx]} :
      (sub == lem_pkg::REG_CTR_LO) ? count_w[idx][31:0] :
      (sub == lem_pkg::REG_CTR_HI) ? {16'h0000, count_w[idx][47:32]} :
      32'h00000000;
   wire [31:0] status_rd = {26'h0000000, retry_pend_q,
      txreq_q == lem_pkg::LEM_TX_WAIT, tx_state_q, rx_state_q};
   wire [31:0] rdata_d =
      !reg_rd_in ? 32'h00000000 :
      ctr_area ? ctr_rd :
      (reg_addr_in == lem_pkg::REG_PWR_CTL) ? {29'h0, pwr_ctl_q} :
      (reg_addr_in == lem_pkg::REG_STATUS) ? status_rd :
      32'h00000000;

   // Counter control registers; reserved bits are dropped on write.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 4; i++) begin
            ctl_lo_q[i] <= lem_pkg::CTL_LO_RST;
            ctl_hi_q[i] <= lem_pkg::CTL_HI_RST;
         end
      end else begin
         if (wr_ctl_lo) begin
            ctl_lo_q[idx] <= reg_wdata_in & lem_pkg::CTL_LO_RW;
         end
         if (wr_ctl_hi) begin
            ctl_hi_q[idx] <= reg_wdata_in[25:0];
         end
      end
   end

   // Power control and read data registers.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pwr_ctl_q <= lem_pkg::PWR_CTL_RST;
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
         if (wr_pwr) begin
            pwr_ctl_q <= reg_wdata_in[2:0];
         end
      end
   end

   // A peer request is legal only with a defined state code.
   wire peer_tgt_ok = ev_peer_tgt_q != 2'b10;
   wire peer_grant = ev_peer_req_q && peer_tgt_ok
      && pwr_ctl_q[lem_pkg::PWR_ALLOW_BIT];

   // Receive direction: we answer, and only an accept moves the state.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_state_q <= lem_pkg::LEM_PWR_FULL;
         accept_q <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         accept_q <= peer_grant;
         refuse_q <= ev_peer_req_q && !peer_grant;
         if (peer_grant) begin
            rx_state_q <= lem_pkg::lem_pwr_t'(ev_peer_tgt_q);
         end
      end
   end

   // Transmit direction: request, then wait for the peer answer.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         txreq_q <= lem_pkg::LEM_TX_IDLE;
         tx_state_q <= lem_pkg::LEM_PWR_FULL;
         tx_target_q <= 2'b00;
         pwr_req_q <= 1'b0;
      end else begin
         pwr_req_q <= tx_start;
         unique case (txreq_q)
            lem_pkg::LEM_TX_IDLE: begin
               if (tx_start) begin
                  tx_target_q <= reg_wdata_in[1:0];
                  txreq_q <= lem_pkg::LEM_TX_WAIT;
               end
            end
            lem_pkg::LEM_TX_WAIT: begin
               if (ev_acc_in_q) begin
                  tx_state_q <= lem_pkg::lem_pwr_t'(tx_target_q);
                  txreq_q <= lem_pkg::LEM_TX_IDLE;
               end else if (ev_ref_in_q) begin
                  txreq_q <= lem_pkg::LEM_TX_IDLE;
               end
            end
         endcase
      end
   end

   // One retry request per outstanding error burst; a new error in the
   // cycle the acknowledge arrives starts a fresh request.
   wire retry_fire = ev_bad_q && (!retry_pend_q || ev_retry_ack_q);
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         retry_req_q <= 1'b0;
         retry_pend_q <= 1'b0;
      end else begin
         retry_req_q <= retry_fire;
         if (retry_fire) begin
            retry_pend_q <= 1'b1;
         end else if (ev_retry_ack_q) begin
            retry_pend_q <= 1'b0;
         end
      end
   end

   // Handshake events: accept in, accept out, refuse in, refuse out.
   wire [3:0] hshake = {refuse_q, ev_ref_in_q, accept_q, ev_acc_in_q};

   // Four identical counters, each free to take any event.
   for (genvar c = 0; c < 4; c++) begin : g_ctr
      logic [8:0] inc;
      lem_event_sel u_sel (
         .code_in(ctl_lo_q[c][7:0]),
         .umask_in(ctl_lo_q[c][lem_pkg::CTL_MASK_LSB +: 8]),
         .opc_en_in(ctl_hi_q[c][lem_pkg::XTRA_OPC_BIT]),
         .rx_state_in(rx_state_q),
         .hshake_in(hshake),
         .crc_err_in(ev_bad_q),
         .retry_sent_in(retry_req_q),
         .credit_in(ev_credit_q),
         .alloc_in(ev_alloc_q),
         .skip_in(ev_skip_q),
         .fill_in(ev_fill_q),
         .flit_valid_in(ev_valid_q),
         .data_flit_in(ev_data_q),
         .dual_slot_in(ev_dual_q),
         .slot_type_in(ev_type_q),
         .hdr_class_in(ev_class_q),
         .hdr_opc_in(ev_opc_q),
         .inc_out(inc)
      );
      lem_counter u_ctr (
         .clk_in(clk_in),
         .reset_n_in(reset_n_in),
         .enable_in(ctl_lo_q[c][lem_pkg::CTL_EN_BIT]),
         .edge_in(ctl_lo_q[c][lem_pkg::CTL_EDGE_BIT]),
         .inc_in(inc),
         .load_lo_in(wr_ctr_lo && idx == c),
         .load_hi_in(wr_ctr_hi && idx == c),
         .wdata_in(reg_wdata_in),
         .count_out(count_w[c])
      );
   end

   // Outputs straight from flip-flops.
   assign reg_rdata_out = rdata_q;
   assign power_change_accept_out = accept_q;
   assign power_change_refuse_out = refuse_q;
   assign pwr_req_out = pwr_req_q;
   assign pwr_target_out = tx_target_q;
   assign rx_state_out = rx_state_q;
   assign tx_state_out = tx_state_q;
   assign retry_req_out = retry_req_q;
endmodule

// File: dv/lem_link_monitor_props.sv
// Checker of the link monitor's handshake, power state and retry timing.
`timescale 1ns/1ps
module lem_link_monitor_props (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Register writes and peer requests.
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic peer_pwr_req_in,
   input wire logic [1:0] peer_pwr_target_in,
   input wire logic power_change_accept_in,
   input wire logic rx_flit_valid_in,
   input wire logic rx_checksum_bad_in,
   input wire logic retry_ack_in,
   // Answers and states.
   input wire logic power_change_accept_out,
   input wire logic power_change_refuse_out,
   input wire logic pwr_req_out,
   input wire logic [1:0] rx_state_out,
   input wire logic [1:0] tx_state_out,
   input wire logic retry_req_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // One answer per request; both at once would leave the peer guessing.
   answer_excl_a: assert property (!(power_change_accept_out &&
      power_change_refuse_out)) else $error("accept and refuse together");
   accept_cause_a: assert property (power_change_accept_out |->
      $past(peer_pwr_req_in, 2)) else $error("accept without request");
   bad_target_a: assert property (peer_pwr_req_in &&
      peer_pwr_target_in == 2'b10 |-> ##2 power_change_refuse_out)
      else $error("illegal target not refused");
   rx_change_a: assert property ($changed(rx_state_out) |->
      power_change_accept_out) else $error("rx state moved unasked");
   rx_target_a: assert property (power_change_accept_out |->
      rx_state_out == $past(peer_pwr_target_in, 2))
      else $error("rx state not the target");
   tx_change_a: assert property ($changed(tx_state_out) |->
      $past(power_change_accept_in, 2)) else $error("tx state moved");
   own_req_a: assert property (pwr_req_out |-> $past(reg_wr_in &&
      reg_addr_in == lem_pkg::REG_PWR_CTL && reg_wdata_in[3]))
      else $error("power request without write");
   retry_cause_a: assert property (retry_req_out |->
      $past(rx_flit_valid_in && rx_checksum_bad_in, 2))
      else $error("retry without checksum error");
   retry_once_a: assert property ((retry_req_out && !retry_ack_in)
      ##1 (!retry_ack_in) [*4] |=> !retry_req_out)
      else $error("second retry while pending");
endmodule
bind lem_link_monitor lem_link_monitor_props props_u (.clk_in, .reset_n_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .peer_pwr_req_in,
   .peer_pwr_target_in, .power_change_accept_in, .rx_flit_valid_in,
   .rx_checksum_bad_in, .retry_ack_in, .power_change_accept_out,
   .power_change_refuse_out, .pwr_req_out, .rx_state_out, .tx_state_out,
   .retry_req_out);

// File: dv/lem_peer_model.sv
// Peer link agent model that answers power requests and retry requests.
`timescale 1ns/1ps
module lem_peer_model (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Answer style chosen by the bench.
   input wire logic refuse_in,
   input wire logic [3:0] delay_in,
   // Requests in, answers out.
   input wire logic pwr_req_in,
   input wire logic retry_req_in,
   output logic accept_out,
   output logic refuse_out,
   output logic retry_ack_out
);
   logic [4:0] pw_q, rt_q;
   // A countdown per request lets the bench make the peer prompt or slow.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pw_q <= 5'h0;
         rt_q <= 5'h0;
         accept_out <= 1'b0;
         refuse_out <= 1'b0;
         retry_ack_out <= 1'b0;
      end else begin
         accept_out <= pw_q == 5'h1 && !refuse_in;
         refuse_out <= pw_q == 5'h1 && refuse_in;
         retry_ack_out <= rt_q == 5'h1;
         pw_q <= pwr_req_in ? {1'b0, delay_in} + 5'h1 :
            (pw_q == 5'h0 ? pw_q : pw_q - 5'h1);
         rt_q <= retry_req_in ? {1'b0, delay_in} + 5'h1 :
            (rt_q == 5'h0 ? rt_q : rt_q - 5'h1);
      end
   end
endmodule

// File: dv/tb_top.sv
// Self-checking bench of the link event monitor.
`timescale 1ns/1ps
module tb_top;
   logic clk_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
   logic [7:0] reg_addr_in = 0;
   logic [31:0] reg_wdata_in = 0, reg_rdata_out, d0, d1;
   logic preq = 0, valid = 0, bad = 0, dflit = 0, p_ref = 0;
   logic [1:0] ptgt = 0, rx_st, tx_st, tgt_o;
   logic acc_o, ref_o, req_o, acc_i, ref_i, retry_o, retry_ack;
   logic [8:0] slots = 0, credit = 0;
   logic [11:0] cls = 0;
   logic [3:0] p_dly = 4'h3;
   int n_fail = 0, n_tests = 0;
   always #25 clk_in = ~clk_in;
   lem_link_monitor dut_u (.clk_in, .reset_n_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
      .peer_pwr_req_in(preq), .peer_pwr_target_in(ptgt),
      .power_change_accept_out(acc_o), .power_change_refuse_out(ref_o),
      .pwr_req_out(req_o), .pwr_target_out(tgt_o),
      .power_change_accept_in(acc_i),
      .power_change_refuse_in(ref_i), .rx_state_out(rx_st),
      .tx_state_out(tx_st), .rx_flit_valid_in(valid),
      .rx_checksum_bad_in(bad), .rx_data_flit_in(dflit),
      .rx_dual_slot_in(1'b0), .rx_slot_type_in(slots), .rx_hdr_class_in(cls),
      .rx_hdr_opc_in(12'h0), .retry_req_out(retry_o),
      .retry_ack_in(retry_ack), .rx_credit_in(credit), .rxq_alloc_in(3'h0),
      .rxq_skip_in(3'h0), .rxq_fill_in(15'h0));
   lem_peer_model peer_u (.clk_in, .reset_n_in, .refuse_in(p_ref),
      .delay_in(p_dly), .pwr_req_in(req_o), .retry_req_in(retry_o),
      .accept_out(acc_i), .refuse_out(ref_i), .retry_ack_out(retry_ack));
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Bus cycles change signals only just after a rising edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
   endtask
   // Enabling first and clearing second drops any stale increment.
   task automatic prog(int n, logic [7:0] code, mask, logic edg);
      wr(8'(n * 16), 32'h00400000 | (32'(edg) << 18) | {16'h0, mask, code});
      wr(8'(n * 16 + 8), 32'h0);
   endtask
   task automatic cnt(int n, string nm, logic [31:0] e);
      rd(8'(n * 16 + 8), d0);
      chk(nm, d0, e);
   endtask
   task automatic flit(logic b, dt, logic [8:0] st, cr, logic [11:0] c);
      @(posedge clk_in);
      {valid, bad, dflit, slots, credit, cls} <= {1'b1, b, dt, st, cr, c};
      @(posedge clk_in);
      {valid, bad, dflit, credit} <= 12'h0;
   endtask
   task automatic peer(logic [1:0] t);
      @(posedge clk_in);
      {preq, ptgt} <= {1'b1, t};
      @(posedge clk_in);
      preq <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
   task automatic t_regs();
      rd(8'h40, d0);
      chk("pwr_ctl", d0, 32'(lem_pkg::PWR_CTL_RST));
      rd(8'h50, d0);
      chk("unmapped", d0, 32'h0);
      wr(8'h30, 32'hffffffff);
      rd(8'h30, d0);
      chk("ctl_lo3", d0, lem_pkg::CTL_LO_RW);
      wr(8'h30, 32'h0);
   endtask
   task automatic t_rx_power();
      prog(0, lem_pkg::EV_SHUTDOWN, 8'h0, 1'b0);
      prog(1, lem_pkg::EV_SHUTDOWN, 8'h0, 1'b1);
      prog(2, lem_pkg::EV_ACK, 8'h02, 1'b0);
      peer(2'b11);
      chk("rx_state", 32'(rx_st), 32'h3);
      chk("tx_state", 32'(tx_st), 32'h0);
      rd(8'h08, d1);
      repeat (8) @(posedge clk_in);
      rd(8'h08, d0);
      chk("shut_cycles", d0 - d1, 32'ha);
      cnt(1, "shut_entries", 32'h1);
      cnt(2, "acks_sent", 32'h1);
   endtask
   task automatic t_refuse();
      wr(8'h40, 32'h0);
      prog(3, lem_pkg::EV_NACK, 8'h02, 1'b0);
      peer(2'b01);
      chk("rx_kept", 32'(rx_st), 32'h3);
      wr(8'h40, 32'h4);
      peer(2'b10);
      cnt(3, "nacks_sent", 32'h2);
   endtask
   task automatic t_own_req();
      prog(0, lem_pkg::EV_ACK, 8'h01, 1'b0);
      wr(8'h40, 32'hd);
      repeat (8) @(posedge clk_in);
      chk("tx_moved", 32'(tx_st), 32'h1);
      chk("tx_target", 32'(tgt_o), 32'h1);
      cnt(0, "acks_recv", 32'h1);
      p_ref <= 1'b1;
      wr(8'h40, 32'hf);
      repeat (8) @(posedge clk_in);
      chk("tx_kept", 32'(tx_st), 32'h1);
      p_ref <= 1'b0;
   endtask
   task automatic t_retry();
      p_dly <= 4'h8;
      prog(0, lem_pkg::EV_CRC_ERR, 8'h0, 1'b0);
      prog(1, lem_pkg::EV_RETRY_SENT, 8'h0, 1'b0);
      repeat (3) flit(1'b1, 1'b0, 9'h0, 9'h0, 12'h0);
      repeat (20) @(posedge clk_in);
      cnt(0, "crc_errors", 32'h3);
      cnt(1, "retries", 32'h1);
      flit(1'b1, 1'b0, 9'h0, 9'h0, 12'h0);
      repeat (6) @(posedge clk_in);
      cnt(1, "retries_again", 32'h2);
      p_dly <= 4'h3;
   endtask
   task automatic t_flits();
      prog(0, lem_pkg::EV_FLIT_CLASS, 8'h0f, 1'b0);
      prog(1, lem_pkg::EV_FLIT_CLASS, 8'h0b, 1'b0);
      prog(2, lem_pkg::EV_HDR_MATCH, 8'h08, 1'b0);
      prog(3, lem_pkg::EV_CRD_SHARED, 8'h07, 1'b0);
      flit(1'b0, 1'b1, 9'h0, 9'h0, 12'h0);
      flit(1'b0, 1'b0, {lem_pkg::SLOT_CRD_FULL, lem_pkg::SLOT_HDR,
         lem_pkg::SLOT_HDR}, 9'h007, 12'h098);
      repeat (4) @(posedge clk_in);
      cnt(0, "data_slots", 32'h3);
      cnt(1, "two_slots", 32'h2);
      cnt(2, "req_match", 32'h1);
      cnt(3, "shared_crd", 32'h3);
      // Credit return in slot two and a header in slot zero both count.
      prog(0, lem_pkg::EV_FLIT_CLASS, 8'h97, 1'b0);
      flit(1'b0, 1'b0, {lem_pkg::SLOT_CRD_FULL, lem_pkg::SLOT_NULL,
         lem_pkg::SLOT_HDR}, 9'h0, 12'h0);
      repeat (4) @(posedge clk_in);
      cnt(0, "crd_and_hdr", 32'h2);
   endtask
   task automatic results();
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // The whole sequence needs well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      results();
   end
   initial begin
      repeat (5) @(posedge clk_in);
      reset_n_in <= 1'b1;
      t_regs();
      t_rx_power();
      t_refuse();
      t_own_req();
      t_retry();
      t_flits();
      results();
   end
endmodule
